/* seq_map.svh */
// Register indices, reset values and timing figures of the start/stop sequencer.
`ifndef SEQ_MAP_SVH
`define SEQ_MAP_SVH

// Register indices; the byte address is four times the index.
`define REG_CTRL        5'd0
`define REG_START_FREQ  5'd1
`define REG_HOLD_TIME   5'd2
`define REG_PRE_CUR     5'd3
`define REG_PRE_TIME    5'd4
`define REG_ACCEL       5'd5
`define REG_DECEL       5'd6
`define REG_S_START     5'd7
`define REG_S_END       5'd8
`define REG_BRK_FREQ    5'd9
`define REG_BRK_WAIT    5'd10
`define REG_BRK_CUR     5'd11
`define REG_BRK_TIME    5'd12
`define REG_DEADTIME    5'd13
`define REG_STOP_SPEED  5'd14
`define REG_STOP_DELAY  5'd15
`define REG_RESTART     5'd16
`define REG_MAX_FREQ    5'd17
`define REG_SETPOINT    5'd18
`define REG_STATUS      5'd19
`define NUM_CFG         19

// Control register fields.
`define CTRL_SRC_LSB    0
`define CTRL_MODE_LSB   2
`define CTRL_SHAPE      4
`define CTRL_STOP       5
`define CTRL_SWITCH_LSB 6
`define CTRL_GUARD      8
`define CTRL_RESTART    9

// Reset values; frequency in 0.01 Hz, current in 0.1 %, times as noted per register.
`define RST_START_FREQ  16'h0032
`define RST_S_SEG       16'h0001
`define RST_STOP_SPEED  16'h0032
`define RST_RESTART     16'h000a
`define RST_MAX_FREQ    16'h1388
`define RST_RAMP_TIME   16'h0064

// Control tick of 10 ms at a 20 ns clock.
`define CLK_PERIOD_NS   20
`define TICK_PERIOD_NS  10000000
`define TICK_CYCLES     (`TICK_PERIOD_NS / `CLK_PERIOD_NS)
`define TICKS_PER_TENTH 10

`endif

/* seq_pkg.sv */
// Types shared by the start/stop sequencer.
package seq_pkg;

   typedef enum logic [1:0] {
      SRC_KEYPAD   = 2'h0,
      SRC_TERMINAL = 2'h1,
      SRC_COMM     = 2'h2
   } cmd_source_t;

   typedef enum logic [1:0] {
      START_DIRECT = 2'h0,
      START_BRAKE  = 2'h1,
      START_TRACK  = 2'h2
   } start_mode_t;

   typedef enum logic [3:0] {
      ST_IDLE       = 4'h0,
      ST_PRE_BRAKE  = 4'h1,
      ST_HOLD       = 4'h3,
      ST_RUN        = 4'h2,
      ST_DECEL      = 4'h6,
      ST_BRAKE_WAIT = 4'h7,
      ST_STOP_BRAKE = 4'h5,
      ST_TRACK      = 4'h4,
      ST_DEADZONE   = 4'hc,
      ST_RESTART    = 4'h8
   } seq_state_t;

endpackage

/* ramp_gen.sv */
// Linear or S-curve frequency ramp toward a target, one 0.01 Hz step at a time; a zero ramp time jumps straight to the target.
`timescale 1ns/1ps
`default_nettype none
module ramp_gen
#(
   parameter int TENTH_CYCLES = 5000000
)
(
   // Clock and reset.
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   // Direct load of the output frequency.
   input  wire logic        load,
   input  wire logic [15:0] load_val,
   // Ramp settings.
   input  wire logic [15:0] target,
   input  wire logic [15:0] max_freq,
   input  wire logic [15:0] accel_time,
   input  wire logic [15:0] decel_time,
   input  wire logic        s_curve,
   input  wire logic [15:0] seg_start,
   input  wire logic [15:0] seg_end,
   // Result.
   output logic      [15:0] freq
);
   import seq_pkg::*;

   typedef struct packed {
      logic [15:0] freq;
      logic [15:0] last_target;
      logic [39:0] acc;
      logic [39:0] seg_cnt;
   } ramp_t;

   ramp_t r_q, r_d;
   logic [15:0] ramp_time;
   logic [15:0] remain;
   logic [39:0] thr;
   logic [39:0] add;
   logic        slow;

   always_comb
   begin
      r_d       = r_q;
      ramp_time = (target > r_q.freq) ? accel_time : decel_time;
      remain    = (target > r_q.freq) ? target - r_q.freq : r_q.freq - target;
      thr       = 40'(ramp_time) * 40'(TENTH_CYCLES);
      // (RULE_07) S-curve soft segments
      slow = s_curve && ((r_q.seg_cnt < 40'(seg_start) * 40'(TENTH_CYCLES)) ||
             (32'(remain) * 32'(ramp_time) <= 32'(max_freq) * 32'(seg_end)));
      // Halving the slope in the segments keeps one accumulator for both shapes.
      add = slow ? 40'(max_freq[15:1]) : 40'(max_freq);
      if (r_q.seg_cnt != 40'hff_ffff_ffff)
         r_d.seg_cnt = r_q.seg_cnt + 40'h1;
      if (target != r_q.last_target)
      begin
         r_d.seg_cnt = 40'h0;
         r_d.acc     = 40'h0;
      end
      r_d.last_target = target;
      // (RULE_07) linear ramp step
      if (load)
      begin
         r_d.freq = load_val;
         r_d.acc  = 40'h0;
      end
      else if (remain == 16'h0)
         r_d.acc = 40'h0;
      else if (ramp_time == 16'h0)
         r_d.freq = target;
      else if (r_q.acc + add >= thr)
      begin
         r_d.acc  = r_q.acc + add - thr;
         r_d.freq = (target > r_q.freq) ? r_q.freq + 16'h1 : r_q.freq - 16'h1;
      end
      else
         r_d.acc = r_q.acc + add;
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
         r_q <= '0;
      else
         r_q <= r_d;
   end

   assign freq = r_q.freq;

   ramp_toward_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      !$past(load) && $past(r_q.freq) < $past(target) && $past(ramp_time) != 16'h0
      |-> r_q.freq - $past(r_q.freq) <= 16'h1) // RULE_07
      else $error("Ramp stepped by more than one unit.");
endmodule
`default_nettype wire

/* start_stop_seq.sv */
// Start/stop sequencer of a variable-frequency drive with its register port.
//
// Behaviour
// (RULE_01) Run commands come from selected source only.
// (RULE_02) Start mode: direct, brake first, or tracking.
// (RULE_03) Direct start begins at programmable starting frequency.
// (RULE_04) Hold starting frequency before accelerating.
// (RULE_05) Brake-first start injects DC current for time.
// (RULE_06) No tracking start for asynchronous motor in mode 0.
// (RULE_07) Ramp is linear or S-curve with segments.
// (RULE_08) Stop mode: ramp down or coast.
// (RULE_09) Stop braking due below threshold frequency.
// (RULE_10) Wait programmed time before stop braking.
// (RULE_11) Stop braking current for time, then stopped.
// (RULE_12) Direction change inserts dead time at switch point.
// (RULE_13) Distinct power-on, power-loss and fault-reset starts.
// (RULE_14) Operator should use direct start for synchronous motors.
// (RULE_15) Operator should brake or track for high inertia.
// (RULE_16) Terminal run at power-on ignored unless enabled; the reset guard clears in the first cycle, as the source resets to keypad.
// (RULE_17) Power-loss restart waits programmed time first.
// (RULE_18) Start phases strictly ordered; stop always honoured.
//
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "seq_map.svh"
module start_stop_seq
#(
   parameter int          TICK_CYCLES = `TICK_CYCLES,
   parameter logic [15:0] ACCEL_RESET = `RST_RAMP_TIME,
   parameter logic [15:0] DECEL_RESET = `RST_RAMP_TIME
)
(
   // Clock and reset.
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   // Register port.
   input  wire logic [6:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   // Run commands of the three sources; rev selects reverse.
   input  wire logic        keypad_run,
   input  wire logic        keypad_rev,
   input  wire logic        terminal_run,
   input  wire logic        terminal_rev,
   input  wire logic        comm_run,
   input  wire logic        comm_rev,
   // Drive conditions.
   input  wire logic        power_ok,
   input  wire logic        fault_active,
   input  wire logic        fault_auto_reset,
   input  wire logic        asynchronous_motor,
   input  wire logic        sensorless_vector_control,
   input  wire logic [15:0] motor_speed_est,
   // Drive outputs.
   output logic      [15:0] out_freq,
   output logic             out_enable,
   output logic             out_reverse,
   output logic             brake_on,
   output logic      [15:0] brake_current
);
   import seq_pkg::*;

   typedef struct packed {
      seq_state_t                 state;
      logic [31:0]                tick_cnt;
      logic [19:0]                timer;
      logic [`NUM_CFG-1:0][15:0] cfg;
      logic                       guard;
      logic                       pl_pending;
      logic [31:0]                rdata;
      logic                       drive_on;
      logic                       brake;
      logic [15:0]                brake_cur;
      logic                       reverse;
   } seq_t;

   seq_t        s_q, s_d;
   logic        tick;
   logic        sel_run;
   logic        sel_rev;
   logic        run_ok;
   logic        timer_done;
   logic [15:0] freq;
   logic [15:0] target;
   logic [15:0] sw_freq;
   logic        rload;
   logic [15:0] rload_val;
   logic [1:0]  src;
   logic [1:0]  smode;
   logic [1:0]  swmode;
   logic [15:0] start_f;
   logic [15:0] set_f;

   function automatic logic [19:0] tenths(input logic [15:0] v);
      return 20'(32'(v) * `TICKS_PER_TENTH);
   endfunction

   function automatic logic [15:0] cfg_reset(input int idx);
      case (idx)
         `REG_START_FREQ: return `RST_START_FREQ;
         `REG_ACCEL:      return ACCEL_RESET;
         `REG_DECEL:      return DECEL_RESET;
         `REG_S_START:    return `RST_S_SEG;
         `REG_S_END:      return `RST_S_SEG;
         `REG_STOP_SPEED: return `RST_STOP_SPEED;
         `REG_RESTART:    return `RST_RESTART;
         `REG_MAX_FREQ:   return `RST_MAX_FREQ;
         default:         return 16'h0;
      endcase
   endfunction

   assign src        = s_q.cfg[`REG_CTRL][`CTRL_SRC_LSB +: 2];
   assign smode      = s_q.cfg[`REG_CTRL][`CTRL_MODE_LSB +: 2];
   assign swmode     = s_q.cfg[`REG_CTRL][`CTRL_SWITCH_LSB +: 2];
   assign start_f    = s_q.cfg[`REG_START_FREQ];
   assign set_f      = (s_q.cfg[`REG_SETPOINT] > s_q.cfg[`REG_MAX_FREQ]) ?
                       s_q.cfg[`REG_MAX_FREQ] : s_q.cfg[`REG_SETPOINT];
   assign tick       = (s_q.tick_cnt == 32'(TICK_CYCLES - 1));
   assign timer_done = (s_q.timer == 20'h0);

   // (RULE_01) command source select
   always_comb
   begin
      unique case (src)
         SRC_KEYPAD:   begin sel_run = keypad_run;   sel_rev = keypad_rev;   end
         SRC_TERMINAL: begin sel_run = terminal_run; sel_rev = terminal_rev; end
         SRC_COMM:     begin sel_run = comm_run;     sel_rev = comm_rev;     end
         default:      begin sel_run = 1'b0;         sel_rev = 1'b0;         end
      endcase
   end

   assign run_ok = sel_run && !s_q.guard && power_ok && !fault_active;

   // (RULE_12) switch-over frequency
   assign sw_freq = (swmode == 2'h1) ? start_f :
                    (swmode == 2'h2) ? s_q.cfg[`REG_STOP_SPEED] : 16'h0;

   always_comb
   begin
      s_d       = s_q;
      rload     = 1'b0;
      rload_val = 16'h0;
      target    = (s_q.state == ST_DEADZONE && swmode == 2'h1) ? start_f : 16'h0;
      s_d.tick_cnt = tick ? 32'h0 : s_q.tick_cnt + 32'h1;
      if (tick && !timer_done)
         s_d.timer = s_q.timer - 20'h1;
      if (reg_wr && reg_addr[6:2] < 5'(`NUM_CFG))
         s_d.cfg[reg_addr[6:2]] = reg_wdata[15:0];
      s_d.rdata = 32'h0;
      if (reg_rd && reg_addr[6:2] < 5'(`NUM_CFG))
         s_d.rdata = {16'h0, s_q.cfg[reg_addr[6:2]]};
      else if (reg_rd && reg_addr[6:2] == `REG_STATUS)
         s_d.rdata = {freq, 9'h0, s_q.brake, s_q.reverse, s_q.drive_on, 4'(s_q.state)};

      // (RULE_16) power-on terminal guard release
      if (!sel_run || src != SRC_TERMINAL || s_q.cfg[`REG_CTRL][`CTRL_GUARD])
         s_d.guard = 1'b0;
      // (RULE_13) fault auto reset allows restart
      if (fault_auto_reset)
         s_d.guard = 1'b0;

      unique case (s_q.state)
         ST_IDLE:
            if (run_ok)
            begin
               // (RULE_02) start mode select
               unique case (smode)
                  START_BRAKE:
                  begin
                     s_d.state = ST_PRE_BRAKE;
                     s_d.timer = 20'(s_q.cfg[`REG_PRE_TIME]);
                  end
                  // (RULE_06) tracking only where supported
                  START_TRACK:
                     if (asynchronous_motor && sensorless_vector_control)
                        s_d.state = ST_HOLD;
                     else
                        s_d.state = ST_TRACK;
                  default:
                     s_d.state = ST_HOLD;
               endcase
               s_d.reverse = sel_rev;
               if (s_d.state == ST_HOLD)
                  s_d.timer = tenths(s_q.cfg[`REG_HOLD_TIME]);
            end
         ST_PRE_BRAKE:
            if (!run_ok)
               s_d.state = ST_IDLE;
            else if (timer_done)
            begin
               s_d.state = ST_HOLD;
               s_d.timer = tenths(s_q.cfg[`REG_HOLD_TIME]);
            end
         ST_TRACK:
            if (!run_ok)
               s_d.state = ST_IDLE;
            else
               s_d.state = ST_RUN;
         ST_HOLD:
         begin
            target = start_f;
            // (RULE_18) stop honoured during hold
            if (!run_ok)
               s_d.state = s_q.cfg[`REG_CTRL][`CTRL_STOP] ? ST_IDLE : ST_DECEL;
            // (RULE_04) hold then accelerate
            else if (timer_done)
               s_d.state = ST_RUN;
         end
         ST_RUN:
         begin
            target = (sel_rev != s_q.reverse) ? 16'h0 : set_f;
            // (RULE_08) stop mode select
            if (!run_ok)
               s_d.state = s_q.cfg[`REG_CTRL][`CTRL_STOP] ? ST_IDLE : ST_DECEL;
            else if (sel_rev != s_q.reverse && freq <= sw_freq)
            begin
               s_d.state = ST_DEADZONE;
               s_d.timer = tenths(s_q.cfg[`REG_DEADTIME]) +
                           ((swmode == 2'h2) ? tenths(s_q.cfg[`REG_STOP_DELAY]) : 20'h0);
            end
         end
         ST_DECEL:
         begin
            // (RULE_09) braking due at threshold
            if (freq <= s_q.cfg[`REG_BRK_FREQ])
            begin
               s_d.state = ST_BRAKE_WAIT;
               s_d.timer = 20'(s_q.cfg[`REG_BRK_WAIT]);
            end
            else if (run_ok && sel_rev == s_q.reverse)
               s_d.state = ST_RUN;
         end
         // (RULE_10) wait before stop braking
         ST_BRAKE_WAIT:
            if (timer_done)
            begin
               s_d.state = ST_STOP_BRAKE;
               s_d.timer = 20'(s_q.cfg[`REG_BRK_TIME]);
            end
         // (RULE_11) stop braking then stopped
         ST_STOP_BRAKE:
            if (timer_done)
               s_d.state = ST_IDLE;
         ST_DEADZONE:
            if (!run_ok)
               s_d.state = ST_IDLE;
            else if (timer_done)
            begin
               s_d.state   = ST_HOLD;
               s_d.reverse = sel_rev;
               s_d.timer   = tenths(s_q.cfg[`REG_HOLD_TIME]);
            end
         // (RULE_17) wait after power returns
         ST_RESTART:
            if (!sel_run)
               s_d.state = ST_IDLE;
            else if (timer_done)
            begin
               s_d.state = ST_HOLD;
               s_d.timer = tenths(s_q.cfg[`REG_HOLD_TIME]);
            end
         default:
            s_d.state = ST_IDLE;
      endcase

      // (RULE_13) power loss and fault drop the output
      if (!power_ok || fault_active)
      begin
         s_d.state      = ST_IDLE;
         s_d.guard      = 1'b1;
         s_d.pl_pending = !power_ok && s_q.cfg[`REG_CTRL][`CTRL_RESTART];
      end
      else if (s_q.pl_pending)
      begin
         s_d.pl_pending = 1'b0;
         s_d.guard      = 1'b0;
         s_d.state      = ST_RESTART;
         s_d.timer      = tenths(s_q.cfg[`REG_RESTART]);
      end

      // (RULE_03) starting frequency on entering hold
      if (s_d.state != s_q.state)
      begin
         rload = 1'b1;
         unique case (s_d.state)
            ST_HOLD:     rload_val = start_f;
            ST_TRACK:    rload_val = (motor_speed_est > s_q.cfg[`REG_MAX_FREQ]) ?
                                     s_q.cfg[`REG_MAX_FREQ] : motor_speed_est;
            ST_DEADZONE: rload_val = (swmode == 2'h1) ? start_f : 16'h0;
            ST_RUN,
            ST_DECEL:    rload = 1'b0;
            default:     rload_val = 16'h0;
         endcase
      end

      // (RULE_05) braking current outputs
      s_d.brake     = (s_d.state == ST_PRE_BRAKE) || (s_d.state == ST_STOP_BRAKE);
      s_d.brake_cur = (s_d.state == ST_PRE_BRAKE)  ? s_q.cfg[`REG_PRE_CUR] :
                      (s_d.state == ST_STOP_BRAKE) ? s_q.cfg[`REG_BRK_CUR] : 16'h0;
      s_d.drive_on  = (s_d.state == ST_HOLD) || (s_d.state == ST_RUN) ||
                      (s_d.state == ST_DECEL) || (s_d.state == ST_TRACK) ||
                      (s_d.state == ST_DEADZONE && swmode == 2'h1);
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         s_q       <= '0;
         s_q.state <= ST_IDLE;
         s_q.guard <= 1'b1;
         for (int i = 0; i < `NUM_CFG; i++)
            s_q.cfg[i] <= cfg_reset(i);
      end
      else
         s_q <= s_d;
   end

   ramp_gen #(
      .TENTH_CYCLES (TICK_CYCLES * `TICKS_PER_TENTH)
   ) u_ramp (
      .core_clk   (core_clk),
      .rst_n      (rst_n),
      .load       (rload),
      .load_val   (rload_val),
      .target     (target),
      .max_freq   (s_q.cfg[`REG_MAX_FREQ]),
      .accel_time (s_q.cfg[`REG_ACCEL]),
      .decel_time (s_q.cfg[`REG_DECEL]),
      .s_curve    (s_q.cfg[`REG_CTRL][`CTRL_SHAPE]),
      .seg_start  (s_q.cfg[`REG_S_START]),
      .seg_end    (s_q.cfg[`REG_S_END]),
      .freq       (freq)
   );

   assign out_freq      = freq;
   assign out_enable    = s_q.drive_on;
   assign out_reverse   = s_q.reverse;
   assign brake_on      = s_q.brake;
   assign brake_current = s_q.brake_cur;
   assign reg_rdata     = s_q.rdata;

   idle_no_run_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_q.state == ST_IDLE && !run_ok && power_ok && !s_q.pl_pending
      |=> s_q.state == ST_IDLE) // RULE_01
      else $error("Left idle without a run command.");
   prestart_brake_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_q.state == ST_PRE_BRAKE |-> brake_on && brake_current == s_q.cfg[`REG_PRE_CUR]) // RULE_05
      else $error("Prestart braking current wrong.");
   hold_freq_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_q.state == ST_HOLD && $past(s_q.state) != ST_HOLD |-> out_freq == start_f) // RULE_03
      else $error("Hold did not start at the starting frequency.");
   coast_stop_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_q.state == ST_RUN && !run_ok && s_q.cfg[`REG_CTRL][`CTRL_STOP]
      |=> s_q.state == ST_IDLE && !out_enable) // RULE_08
      else $error("Coast stop did not remove the output.");
   brake_due_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_q.state == ST_DECEL && freq <= s_q.cfg[`REG_BRK_FREQ] && power_ok && !fault_active
      |=> s_q.state == ST_BRAKE_WAIT) // RULE_09
      else $error("Stop braking not due at threshold.");
   brake_wait_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_q.state == ST_BRAKE_WAIT |-> !brake_on && !out_enable) // RULE_10
      else $error("Output active while waiting to brake.");
   stop_brake_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_q.state == ST_STOP_BRAKE |-> brake_current == s_q.cfg[`REG_BRK_CUR]) // RULE_11
      else $error("Stop braking current wrong.");
   dir_switch_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      $changed(out_reverse) |-> $past(s_q.state) inside {ST_DEADZONE, ST_IDLE}) // RULE_12
      else $error("Direction changed outside the dead time.");
   start_order_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_q.state == ST_RUN && $past(s_q.state) != ST_RUN
      |-> $past(s_q.state) inside {ST_HOLD, ST_TRACK, ST_DECEL}) // RULE_18
      else $error("Run entered out of order.");
   track_allowed_a: assert property (@(posedge core_clk) disable iff (!rst_n)
      s_q.state == ST_TRACK && $past(s_q.state) == ST_IDLE
      |-> !$past(asynchronous_motor && sensorless_vector_control)) // RULE_06
      else $error("Tracking start where unsupported.");
endmodule
`default_nettype wire

/* cmd_src_model.sv */
// Model of the three command sources that feed the sequencer.
`timescale 1ns/1ps
`default_nettype none
module cmd_src_model
(
   // Clock.
   input  wire logic       core_clk,
   // Requested source, run, direction and stray activity on the others.
   input  wire logic [1:0] sel,
   input  wire logic       run,
   input  wire logic       rev,
   input  wire logic       noise,
   // Run and reverse lines, keypad at bit 0.
   output logic      [2:0] run_o,
   output logic      [2:0] rev_o
);
   logic [2:0] lfsr_q = 3'h5;

   always_ff @(posedge core_clk)
   begin
      lfsr_q <= {lfsr_q[1:0], lfsr_q[2] ^ lfsr_q[1]};
   end

   // Unselected sources toggle their run lines while noise is high and their reverse lines always, so a leak from them shows up.
   always_comb
   begin
      for (int i = 0; i < 3; i++)
      begin
         run_o[i] = (sel == i) ? run : (noise & lfsr_q[i]);
         rev_o[i] = (sel == i) ? rev : lfsr_q[i];
      end
   end
endmodule
`default_nettype wire

/* start_stop_seq_tb.sv */
// Self-checking bench of the start/stop sequencer.
`timescale 1ns/1ps
`default_nettype none
`include "seq_map.svh"
module start_stop_seq_tb;
   logic        core_clk, rst_n, reg_wr, reg_rd, cmd_run, cmd_rev, noise, power_ok;
   logic        fault_active, fault_auto_reset, asynchronous_motor, sensorless_vector_control;
   logic        out_enable, out_reverse, brake_on;
   logic [1:0]  sel;
   logic [2:0]  run_l, rev_l;
   logic [6:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata;
   logic [15:0] motor_speed_est, out_freq, brake_current, sf, bc, last;
   logic [4:0]  ri [10] = '{1, 5, 6, 7, 8, 14, 16, 17, 19, 20};
   logic [15:0] rv [10] = '{16'h32, 16'h64, 16'h64, 16'h1, 16'h1, 16'h32, 16'ha, 16'h1388, 0, 0};
   int          errors, num_checks, n, seed;

   cmd_src_model src (.core_clk(core_clk), .sel(sel), .run(cmd_run), .rev(cmd_rev),
      .noise(noise), .run_o(run_l), .rev_o(rev_l));

   start_stop_seq #(.TICK_CYCLES(10)) dut
   (
      .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .keypad_run(run_l[0]), .keypad_rev(rev_l[0]), .terminal_run(run_l[1]),
      .terminal_rev(rev_l[1]), .comm_run(run_l[2]), .comm_rev(rev_l[2]),
      .power_ok(power_ok), .fault_active(fault_active), .fault_auto_reset(fault_auto_reset),
      .asynchronous_motor(asynchronous_motor),
      .sensorless_vector_control(sensorless_vector_control),
      .motor_speed_est(motor_speed_est), .out_freq(out_freq), .out_enable(out_enable),
      .out_reverse(out_reverse), .brake_on(brake_on), .brake_current(brake_current)
   );

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         errors++;
         $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
      end
   endtask

   task automatic wr(input logic [4:0] idx, input logic [15:0] d);
      @(posedge core_clk);
      reg_addr  <= {idx, 2'h0};
      reg_wdata <= {16'h0, d};
      reg_wr    <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [4:0] idx, input logic [15:0] e);
      @(posedge core_clk);
      reg_addr <= {idx, 2'h0};
      reg_rd   <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      @(negedge core_clk);
      chk("reg_rdata", reg_rdata, {16'h0, e});
   endtask

   // Outputs are read just after the edge, before that edge's updates land.
   task automatic wt(input int w, input logic val, input int maxc);
      n = 0;
      do
      begin
         @(posedge core_clk);
         n++;
      end
      while (((w == 0) ? out_enable : (w == 1) ? brake_on : out_reverse) !== val && n < maxc);
   endtask

   task automatic reach();
      n = 0;
      while (out_freq !== 16'h012c && n < 3000)
      begin
         @(posedge core_clk);
         n++;
      end
      chk("out_freq", out_freq, 16'h012c);
   endtask

   task automatic wrap_up();
      $display("checks %0d, errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   initial
   begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   initial
   begin
      repeat (60000) @(posedge core_clk);
      errors++;
      wrap_up();
   end

   initial
   begin
      {rst_n, reg_wr, reg_rd, cmd_run, cmd_rev, noise, fault_active, fault_auto_reset} = '0;
      {reg_addr, reg_wdata, sel, motor_speed_est, sensorless_vector_control} = '0;
      power_ok = 1'b1;
      asynchronous_motor = 1'b1;
      seed = 32'h9716;
      errors = 0;
      num_checks = 0;
      sf = 16'h10 + 16'($random(seed) & 32'h3f);
      bc = 16'h1 + 16'($random(seed) & 32'h1ff);
      repeat (3) @(posedge core_clk);
      rst_n <= 1'b1;
      wr(5'd19, 16'hffff);
      wr(5'd20, 16'hffff);
      for (int i = 0; i < 10; i++)
         rd(ri[i], rv[i]);
      wr(`REG_MAX_FREQ, 16'h03e8);
      wr(`REG_ACCEL, 16'h0001);
      wr(`REG_DECEL, 16'h0001);
      wr(`REG_SETPOINT, 16'h012c);
      wr(`REG_START_FREQ, sf);
      wr(`REG_HOLD_TIME, 16'h0002);
      wr(`REG_PRE_CUR, 16'h00c8);
      wr(`REG_PRE_TIME, 16'h0002);
      wr(`REG_BRK_FREQ, 16'h0064);
      wr(`REG_BRK_WAIT, 16'h0002);
      wr(`REG_BRK_CUR, bc);
      wr(`REG_BRK_TIME, 16'h0003);
      wr(`REG_DEADTIME, 16'h0001);
      motor_speed_est <= 16'h00c8;
      // Each pass: another source and stop mode; start modes direct, brake, track, track; S-curve ramp in the last pass only.
      for (int k = 0; k < 4; k++)
      begin
         sel <= 2'(k % 3);
         sensorless_vector_control <= (k == 3);
         wr(`REG_CTRL, 16'((k % 3) | ((k > 1 ? 2 : k) << 2) | ((k == 3) << 4) | ((k & 1) << 5)));
         noise <= 1'b1;
         wt(0, 1'b1, 40);
         chk("out_enable", out_enable, 1'b0);
         noise <= 1'b0;
         cmd_run <= 1'b1;
         if (k == 1)
         begin
            wt(1, 1'b1, 20);
            chk("brake_current", brake_current, 16'h00c8);
            chk("out_enable", out_enable, 1'b0);
            wt(1, 1'b0, 40);
            chk("brake_len", 32'(n >= 10 && n <= 31), 1);
         end
         wt(0, 1'b1, 60);
         chk("out_freq", out_freq, (k == 2) ? 16'h00c8 : sf);
         if (k != 2)
         begin
            repeat (100) @(posedge core_clk);
            chk("out_freq", out_freq, sf);
         end
         reach();
         cmd_run <= 1'b0;
         if (k[0])
         begin
            repeat (3) @(posedge core_clk);
            chk("out_enable", out_enable, 1'b0);
            chk("brake_on", brake_on, 1'b0);
         end
         else
         begin
            n = 0;
            while (out_enable !== 1'b0 && n < 3000)
            begin
               last = out_freq;
               @(posedge core_clk);
               n++;
            end
            chk("stop_freq", 32'(last <= 16'h0064 && out_enable === 1'b0), 1);
            wt(1, 1'b1, 40);
            chk("brake_wait", 32'(n >= 10 && n <= 31), 1);
            chk("brake_current", brake_current, bc);
            wt(1, 1'b0, 50);
            chk("brake_len", 32'(n >= 20 && n <= 41), 1);
         end
      end
      sel <= 2'h1;
      wr(`REG_CTRL, 16'h0001);
      cmd_run <= 1'b1;
      reach();
      cmd_rev <= 1'b1;
      wt(2, 1'b1, 3000);
      chk("switch_freq", 32'(out_freq <= sf && out_reverse === 1'b1), 1);
      reach();
      wr(`REG_CTRL, 16'h0041);
      cmd_rev <= 1'b0;
      repeat (300) @(posedge core_clk);
      chk("switch_hold", {out_freq, out_enable, out_reverse}, {sf, 2'b11});
      fault_active <= 1'b1;
      repeat (3) @(posedge core_clk);
      chk("out_enable", out_enable, 1'b0);
      fault_active <= 1'b0;
      wt(0, 1'b1, 50);
      chk("out_enable", out_enable, 1'b0);
      fault_auto_reset <= 1'b1;
      @(posedge core_clk);
      fault_auto_reset <= 1'b0;
      wt(0, 1'b1, 20);
      chk("out_enable", out_enable, 1'b1);
      wr(`REG_CTRL, 16'h0201);
      power_ok <= 1'b0;
      repeat (3) @(posedge core_clk);
      chk("out_enable", out_enable, 1'b0);
      power_ok <= 1'b1;
      wt(0, 1'b1, 1200);
      chk("restart_wait", 32'(n >= 990 && n <= 1011), 1);
      rst_n <= 1'b0;
      repeat (3) @(posedge core_clk);
      rst_n <= 1'b1;
      wr(`REG_CTRL, 16'h0001);
      // Power returns with the terminal run still held.
      power_ok <= 1'b0;
      repeat (3) @(posedge core_clk);
      power_ok <= 1'b1;
      wt(0, 1'b1, 50);
      chk("out_enable", out_enable, 1'b0);
      cmd_run <= 1'b0;
      repeat (2) @(posedge core_clk);
      cmd_run <= 1'b1;
      wt(0, 1'b1, 20);
      chk("out_enable", out_enable, 1'b1);
      wrap_up();
   end
endmodule
`default_nettype wire
